// file: sdi_defines.vh
// Constants for the serial display interface.
// Assumes inclusion by bare name from the design files.
`ifndef SDI_DEFINES_VH
`define SDI_DEFINES_VH
`define SDI_VAR_3W        2'h0
`define SDI_VAR_4W        2'h1
`define SDI_VAR_5W1       2'h2
`define SDI_VAR_5W2       2'h3
`define SDI_PRE_MAX       16
`define SDI_PRE_LEN_W     5
`define SDI_WORD_MAX      16
`define SDI_WORD_LEN_W    5
`define SDI_DIV_RESET     8'h02
`define SDI_FIFO_DEPTH    16
`define SDI_ST_IDLE       3'h0
`define SDI_ST_PRE        3'h1
`define SDI_ST_CTL1       3'h2
`define SDI_ST_CTL2       3'h3
`define SDI_ST_DATA       3'h4
`define SDI_ST_GAP        3'h5
`define SDI_ST_DONE       3'h6
`endif

// file: sdi_fifo.v
// Synchronous FIFO for transfer words.
// Assumes one clock, synchronous active-high reset, clock enable.
`timescale 1ns/10ps
module sdi_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             reset,
    input  wire             clk_en,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    assign in_ready  = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (clk_en && push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                             wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                             rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// file: sdi_serial_display.v
// Serial display interface master with two channel configurations.
// Assumes configuration ports stay stable while busy is high.
`timescale 1ns/10ps
`include "sdi_defines.vh"
//
// Contract
// - Four variants are selectable: 3-wire, 4-wire, 5-wire type 1 and type 2.
// - Type 1 has the display sample select on the clock, type 2 on chip select.
// - The 3-wire variant uses separate in/out data plus an output enable for the pad.
// - An optional preamble of programmable length and content precedes each transfer.
// - A read/write bit and a register-select bit follow, in programmable order.
// - The read/write bit can be disabled so select goes straight to data.
// - The data phase carries one word or a continuous burst of words.
// - In type 1 the separate select line changes only at word boundaries.
// - Each of two channels holds its own variant, preamble and control options.
module sdi_serial_display #(
    parameter WORD_W = `SDI_WORD_MAX,
    parameter PRE_W  = `SDI_PRE_MAX,
    parameter DEPTH  = `SDI_FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire                       clk_sys,
    input  wire                       reset,
    input  wire                       clk_en,
    // Channel configuration, index 0 and 1; cfg_clk_div is shared by both channels
    input  wire [3:0]                 cfg_variant,
    input  wire [2*`SDI_PRE_LEN_W-1:0] cfg_pre_len,
    input  wire [2*PRE_W-1:0]         cfg_pre_bits,
    input  wire [1:0]                 cfg_rw_en,
    input  wire [1:0]                 cfg_rs_first,
    input  wire [2*`SDI_WORD_LEN_W-1:0] cfg_word_len,
    input  wire [7:0]                 cfg_clk_div,
    // Transfer word stream: {last, select, data}
    input  wire                       word_valid,
    output wire                       word_ready,
    input  wire [WORD_W-1:0]          word_data,
    input  wire                       word_select,
    input  wire                       word_last,
    input  wire                       xfer_channel,
    input  wire                       xfer_read,
    // Read data back
    output reg                        rd_valid_ff,
    output reg  [WORD_W-1:0]          rd_data_ff,
    output wire                       busy,
    // Display pins
    output reg  [1:0]                 display_chip_select_n_ff,
    output reg                        serial_display_clock_ff,
    output reg                        serial_data_out_ff,
    output reg                        serial_data_out_enable_ff,
    output reg                        register_select_bit_ff,
    input  wire                       serial_data_in
);
    localparam FW = WORD_W + 2;

    wire            f_valid;
    reg             f_pop;
    wire [FW-1:0]   f_data;

    reg  [2:0]      st_ff;
    reg             ch_ff;
    reg  [1:0]      var_ff;
    reg             rd_ff;
    reg  [`SDI_PRE_LEN_W-1:0]  cnt_ff;
    reg  [PRE_W-1:0]           pre_sh_ff;
    reg  [WORD_W-1:0]          sh_ff;
    reg  [WORD_W-1:0]          in_sh_ff;
    reg             sel_ff;
    reg             last_ff;
    reg  [7:0]      div_ff;
    reg             phase_ff;
    reg  [2:0]      sync_ff;
    reg             din_ff;

    sdi_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_valid  (word_valid),
        .in_ready  (word_ready),
        .in_data   ({word_last, word_select, word_data}),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    function [`SDI_PRE_LEN_W-1:0] pick_len;
        input [2*`SDI_PRE_LEN_W-1:0] v;
        input                        c;
        begin
            pick_len = c ? v[2*`SDI_PRE_LEN_W-1:`SDI_PRE_LEN_W] :
                           v[`SDI_PRE_LEN_W-1:0];
        end
    endfunction

    assign busy = (st_ff != `SDI_ST_IDLE);

    // Pin input: three stages, change counted when stages two and three agree
    always @(posedge clk_sys) begin
        if (reset) begin
            sync_ff <= 3'h0;
            din_ff  <= 1'b0;
        end else if (clk_en) begin
            sync_ff <= {sync_ff[1:0], serial_data_in};
            if (sync_ff[1] == sync_ff[2]) begin
                din_ff <= sync_ff[2];
            end
        end
    end

    // Bit tick: half period timer
    wire tick = (div_ff == 8'h00);
    wire fall = tick && phase_ff;
    wire rw_bit = rd_ff;
    wire rs_first = cfg_rs_first[ch_ff];
    wire rw_on = cfg_rw_en[ch_ff];
    wire [`SDI_WORD_LEN_W-1:0] wlen = pick_len(cfg_word_len, ch_ff);

    always @(posedge clk_sys) begin
        if (reset) begin
            st_ff                     <= `SDI_ST_IDLE;
            ch_ff                     <= 1'b0;
            var_ff                    <= `SDI_VAR_3W;
            rd_ff                     <= 1'b0;
            cnt_ff                    <= {`SDI_PRE_LEN_W{1'b0}};
            pre_sh_ff                 <= {PRE_W{1'b0}};
            sh_ff                     <= {WORD_W{1'b0}};
            in_sh_ff                  <= {WORD_W{1'b0}};
            sel_ff                    <= 1'b0;
            last_ff                   <= 1'b0;
            div_ff                    <= `SDI_DIV_RESET;
            phase_ff                  <= 1'b0;
            f_pop                     <= 1'b0;
            rd_valid_ff               <= 1'b0;
            rd_data_ff                <= {WORD_W{1'b0}};
            display_chip_select_n_ff  <= 2'h3;
            serial_display_clock_ff   <= 1'b0;
            serial_data_out_ff        <= 1'b0;
            serial_data_out_enable_ff <= 1'b0;
            register_select_bit_ff    <= 1'b0;
        end else if (clk_en) begin
            f_pop       <= 1'b0;
            rd_valid_ff <= 1'b0;
            if (st_ff != `SDI_ST_IDLE) begin
                div_ff <= tick ? cfg_clk_div : div_ff - 8'h01;
                if (tick && st_ff != `SDI_ST_GAP && st_ff != `SDI_ST_DONE) begin
                    phase_ff                <= ~phase_ff;
                    serial_display_clock_ff <= ~phase_ff;
                end
            end
            case (st_ff)
                `SDI_ST_IDLE: begin
                    if (f_valid && !f_pop) begin
                        ch_ff     <= xfer_channel;
                        var_ff    <= xfer_channel ? cfg_variant[3:2] : cfg_variant[1:0];
                        rd_ff     <= xfer_read;
                        pre_sh_ff <= xfer_channel ? cfg_pre_bits[2*PRE_W-1:PRE_W] :
                                                    cfg_pre_bits[PRE_W-1:0];
                        cnt_ff    <= pick_len(cfg_pre_len, xfer_channel);
                        sh_ff     <= f_data[WORD_W-1:0];
                        sel_ff    <= f_data[WORD_W];
                        last_ff   <= f_data[WORD_W+1];
                        f_pop     <= 1'b1;
                        div_ff    <= cfg_clk_div;
                        phase_ff  <= 1'b0;
                        display_chip_select_n_ff[xfer_channel] <= 1'b0;
                        serial_data_out_enable_ff <= 1'b1;
                        st_ff <= (pick_len(cfg_pre_len, xfer_channel) != 0) ?
                                 `SDI_ST_PRE : `SDI_ST_CTL1;
                        // first preamble bit, else first control bit
                        if (pick_len(cfg_pre_len, xfer_channel) != 0) begin
                            serial_data_out_ff <= xfer_channel ? cfg_pre_bits[2*PRE_W-1] :
                                                                 cfg_pre_bits[PRE_W-1];
                        end else if (cfg_rs_first[xfer_channel] || !cfg_rw_en[xfer_channel]) begin
                            serial_data_out_ff <= f_data[WORD_W];
                        end else begin
                            serial_data_out_ff <= xfer_read;
                        end
                        // type 2 select valid at chip select
                        if ((xfer_channel ? cfg_variant[3:2] : cfg_variant[1:0]) ==
                            `SDI_VAR_5W2) begin
                            register_select_bit_ff <= f_data[WORD_W];
                        end
                    end
                end
                `SDI_ST_PRE: begin
                    if (fall) begin
                        pre_sh_ff <= {pre_sh_ff[PRE_W-2:0], 1'b0};
                        cnt_ff    <= cnt_ff - 1'b1;
                        if (cnt_ff == 1) begin
                            st_ff <= `SDI_ST_CTL1;
                            serial_data_out_ff <= (rs_first || !rw_on) ? sel_ff : rw_bit;
                        end else begin
                            serial_data_out_ff <= pre_sh_ff[PRE_W-2];
                        end
                    end
                end
                `SDI_ST_CTL1: begin
                    if (fall) begin
                        if (rw_on) begin
                            st_ff <= `SDI_ST_CTL2;
                            serial_data_out_ff <= rs_first ? rw_bit : sel_ff;
                        end else begin
                            st_ff  <= `SDI_ST_DATA;
                            cnt_ff <= wlen;
                            serial_data_out_ff <= sh_ff[WORD_W-1];
                        end
                    end
                end
                `SDI_ST_CTL2: begin
                    if (fall) begin
                        st_ff  <= `SDI_ST_DATA;
                        cnt_ff <= wlen;
                        serial_data_out_ff <= sh_ff[WORD_W-1];
                        if (rd_ff && var_ff == `SDI_VAR_3W) begin
                            serial_data_out_enable_ff <= 1'b0;
                        end
                    end
                end
                `SDI_ST_DATA: begin
                    // type 1 and type 2 select follow the current word
                    if (var_ff == `SDI_VAR_5W1 || var_ff == `SDI_VAR_5W2) begin
                        register_select_bit_ff <= sel_ff;
                    end
                    if (tick && !phase_ff) begin
                        in_sh_ff <= {in_sh_ff[WORD_W-2:0], din_ff};
                    end
                    if (fall) begin
                        sh_ff  <= {sh_ff[WORD_W-2:0], 1'b0};
                        cnt_ff <= cnt_ff - 1'b1;
                        serial_data_out_ff <= sh_ff[WORD_W-2];
                        if (cnt_ff == 1) begin
                            if (rd_ff) begin
                                rd_valid_ff <= 1'b1;
                                rd_data_ff  <= in_sh_ff;
                            end
                            st_ff <= `SDI_ST_GAP;
                        end
                    end
                end
                `SDI_ST_GAP: begin
                    if (!last_ff && f_valid && !f_pop) begin
                        sh_ff    <= f_data[WORD_W-1:0];
                        sel_ff   <= f_data[WORD_W];
                        last_ff  <= f_data[WORD_W+1];
                        f_pop    <= 1'b1;
                        cnt_ff   <= wlen;
                        serial_data_out_ff <= f_data[WORD_W-1];
                        st_ff    <= `SDI_ST_DATA;
                        // type 1 select moves at word boundary
                        if (var_ff == `SDI_VAR_5W1) begin
                            register_select_bit_ff <= f_data[WORD_W];
                        end
                    end else if (last_ff) begin
                        st_ff <= `SDI_ST_DONE;
                    end
                end
                `SDI_ST_DONE: begin
                    display_chip_select_n_ff  <= 2'h3;
                    serial_data_out_enable_ff <= 1'b0;
                    serial_display_clock_ff   <= 1'b0;
                    phase_ff                  <= 1'b0;
                    st_ff                     <= `SDI_ST_IDLE;
                end
                default: begin
                    st_ff <= `SDI_ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: sdi_serial_display_monitor.sv
// Pin checker for the serial display master.
// Assumes a bind onto sdi_serial_display.
`timescale 1ns/10ps
module sdi_serial_display_monitor (
    // Clock and reset
    input wire       clk_sys,
    input wire       reset,
    // Watched ports
    input wire [7:0] cfg_clk_div,
    input wire       word_ready,
    input wire       busy,
    input wire       rd_valid_ff,
    input wire [1:0] display_chip_select_n_ff,
    input wire       serial_display_clock_ff,
    input wire       serial_data_out_ff,
    input wire       serial_data_out_enable_ff,
    input wire       register_select_bit_ff
);
    reg  [8:0] high_cnt_ff;
    wire       idle = &display_chip_select_n_ff;
    wire       sclk = serial_display_clock_ff;
    // Cycles spent in the high phase
    always @(posedge clk_sys) begin
        if (reset || !sclk)
            high_cnt_ff <= 9'h000;
        else
            high_cnt_ff <= high_cnt_ff + 9'h001;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    one_select_a: assert property (display_chip_select_n_ff != 2'h0)
        else $error("both chip selects low");
    clock_idle_a: assert property (idle |-> !sclk)
        else $error("serial clock high outside frame");
    half_period_a: assert property ($fell(sclk) && !$past(reset)
        |-> high_cnt_ff == cfg_clk_div + 9'h001) else $error("high phase length wrong");
    first_edge_a: assert property ($fell(display_chip_select_n_ff[0]) |-> ##[1:300] sclk)
        else $error("no serial clock after select");
    data_hold_a: assert property (sclk && $past(sclk) |-> $stable(serial_data_out_ff))
        else $error("data moved while clock high");
    enable_frame_a: assert property (serial_data_out_enable_ff |-> !idle)
        else $error("data driven outside frame");
    select_hold_a: assert property ($changed(register_select_bit_ff) |-> !sclk)
        else $error("select moved inside a bit");
    cs_edge_a: assert property ($changed(display_chip_select_n_ff) |-> !sclk)
        else $error("select moved with clock high");
    rd_pulse_a: assert property (rd_valid_ff |=> !rd_valid_ff)
        else $error("read strobe longer than one cycle");
    full_busy_a: assert property (!word_ready |-> busy)
        else $error("refusing words while idle");
    cover property (rd_valid_ff);
    cover property ($fell(display_chip_select_n_ff[1]));
    cover property (!word_ready);
endmodule
bind sdi_serial_display sdi_serial_display_monitor u_mon (.clk_sys, .reset, .cfg_clk_div,
    .word_ready, .busy, .rd_valid_ff, .display_chip_select_n_ff, .serial_display_clock_ff,
    .serial_data_out_ff, .serial_data_out_enable_ff, .register_select_bit_ff);

// file: sdi_display_model.sv
// Display module model on the serial side of the master.
// Assumes one selected channel at a time; shared line in 3-wire use.
`timescale 1ns/10ps
module sdi_display_model #(
    parameter [15:0] REPLY = 16'hb1e4
) (
    // Pins from the master
    input  wire        clk_sys,
    input  wire        cs_n,
    input  wire        sclk,
    input  wire        sdo,
    input  wire        sdo_en,
    input  wire        rs,
    input  wire        three_wire,
    // Line back to the master and observed frame
    output wire        sdi,
    output reg  [63:0] cap_ff = 64'h0,
    output reg  [7:0]  cnt_ff = 8'h00,
    output reg         rs_ff = 1'b0
);
    reg [15:0] rep_ff = 16'h0;
    reg        last_ff = 1'b0;
    reg        sclk_d_ff = 1'b0;
    reg        cs_d_ff = 1'b1;
    wire       drv = !cs_n && !(three_wire && sdo_en);
    wire       line = drv ? rep_ff[15] : ~last_ff;
    assign sdi = (three_wire && sdo_en) ? sdo : line;
    always @(posedge clk_sys) begin
        sclk_d_ff <= sclk;
        cs_d_ff <= cs_n;
        last_ff <= line;
        if (cs_d_ff && !cs_n) begin
            cnt_ff <= 8'h00;
            rep_ff <= REPLY;
            rs_ff <= rs;
        end else if (!cs_n && sclk && !sclk_d_ff) begin
            cap_ff <= {cap_ff[62:0], three_wire ? sdi : sdo};
            cnt_ff <= cnt_ff + 8'h01;
            rs_ff <= rs;
        end else if (!cs_n && !sclk && sclk_d_ff)
            rep_ff <= {rep_ff[14:0], rep_ff[15]};
    end
endmodule

// file: sdi_serial_display_test.sv
// Self-checking bench for the serial display master.
// Assumes the display model and the bound pin checker.
`timescale 1ns/10ps
`include "sdi_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sdi_serial_display_test;
    typedef struct packed {
        logic ch; logic [1:0] vr; logic [4:0] pl; logic [15:0] pre; logic rw;
        logic rsf; logic [4:0] wl; logic [15:0] dat; logic sel; logic rd;
    } sdi_row_t;
    localparam [15:0] REPLY = 16'hb1e4;
    logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, word_valid = 1'b0;
    logic word_select = 1'b0, word_last = 1'b0, xfer_channel = 1'b0, xfer_read = 1'b0;
    logic [3:0] cfg_variant = 4'h0;
    logic [9:0] cfg_pre_len = 10'h000, cfg_word_len = 10'h021;
    logic [31:0] cfg_pre_bits = 32'h0;
    logic [1:0] cfg_rw_en = 2'h0, cfg_rs_first = 2'h0, cs_seen = 2'h0;
    logic [7:0] cfg_clk_div = 8'h07;
    logic [15:0] word_data = 16'h0, rd_seen = 16'h0;
    int num_errors = 0, num_checks = 0;
    wire word_ready, rd_valid_ff, busy, serial_display_clock_ff, serial_data_out_ff;
    wire serial_data_out_enable_ff, register_select_bit_ff, serial_data_in, rs_cap;
    wire [15:0] rd_data_ff;
    wire [1:0] display_chip_select_n_ff;
    wire [63:0] cap;
    wire [7:0] cnt;
    sdi_serial_display dut (.clk_sys, .reset, .clk_en, .cfg_variant, .cfg_pre_len,
        .cfg_pre_bits, .cfg_rw_en, .cfg_rs_first, .cfg_word_len, .cfg_clk_div,
        .word_valid, .word_ready, .word_data, .word_select, .word_last, .xfer_channel,
        .xfer_read, .rd_valid_ff, .rd_data_ff, .busy, .display_chip_select_n_ff,
        .serial_display_clock_ff, .serial_data_out_ff, .serial_data_out_enable_ff,
        .register_select_bit_ff, .serial_data_in);
    sdi_display_model #(.REPLY(REPLY)) mdl (.clk_sys, .cs_n(&display_chip_select_n_ff),
        .sclk(serial_display_clock_ff), .sdo(serial_data_out_ff),
        .sdo_en(serial_data_out_enable_ff), .rs(register_select_bit_ff),
        .three_wire(cfg_variant[2*xfer_channel +: 2] == `SDI_VAR_3W),
        .sdi(serial_data_in), .cap_ff(cap), .cnt_ff(cnt), .rs_ff(rs_cap));
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cs_seen <= cs_seen | ~display_chip_select_n_ff;
        if (rd_valid_ff === 1'b1)
            rd_seen <= rd_data_ff;
    end
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Other channel gets opposite settings
    task automatic setcfg(input sdi_row_t r);
        cfg_variant = {2{~r.vr}};
        cfg_pre_len = {2{5'h10 - r.pl}};
        cfg_pre_bits = {2{~r.pre}};
        cfg_rw_en = {2{~r.rw}};
        cfg_rs_first = {2{~r.rsf}};
        cfg_word_len = {2{5'h11 - r.wl}};
        cfg_variant[2*r.ch +: 2] = r.vr;
        cfg_pre_len[5*r.ch +: 5] = r.pl;
        cfg_pre_bits[16*r.ch +: 16] = r.pre;
        cfg_rw_en[r.ch] = r.rw;
        cfg_rs_first[r.ch] = r.rsf;
        cfg_word_len[5*r.ch +: 5] = r.wl;
        xfer_channel = r.ch;
        xfer_read = r.rd;
        cs_seen = 2'h0;
        rd_seen = 16'hxxxx;
    endtask
    task automatic push(input [15:0] d, input s, input l);
        word_data = d;
        word_select = s;
        word_last = l;
        word_valid = 1'b1;
        while (word_ready !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1 word_valid = 1'b0;
    endtask
    task automatic drain;
        do begin
            @(posedge clk_sys);
            #1;
        end while (busy !== 1'b0);
    endtask
    function automatic [71:0] expect_bits(input sdi_row_t r);
        logic [63:0] b;
        logic [7:0]  n;
        b = 64'h0;
        n = 8'h00;
        for (int i = r.pl; i > 0; i--) begin
            b = {b[62:0], r.pre[i-1]};
            n++;
        end
        if (r.rw) b = {b[61:0], r.rsf ? {r.sel, r.rd} : {r.rd, r.sel}};
        else b = {b[62:0], r.sel};
        n = n + (r.rw ? 8'h02 : 8'h01);
        for (int i = 0; i < r.wl; i++)
            b = {b[62:0], r.dat[15-i]};
        return {n + {3'h0, r.wl}, b};
    endfunction
    function automatic [15:0] expect_read(input sdi_row_t r);
        logic [15:0] e;
        int          n0;
        e = 16'h0;
        n0 = r.pl + (r.rw ? 2 : 1);
        for (int i = 0; i < r.wl; i++)
            e = {e[14:0], REPLY[(31 - n0 - i) % 16]};
        return e;
    endfunction
    task automatic run_row(input sdi_row_t r);
        logic [71:0] ex;
        logic [63:0] m;
        setcfg(r);
        push(r.dat, r.sel, 1'b1);
        drain();
        ex = expect_bits(r);
        m = (64'h1 << ex[71:64]) - 64'h1;
        `CHK(cs_seen, 2'h1 << r.ch)
        if (r.vr < `SDI_VAR_5W1) `CHK(cnt, ex[71:64])
        if (r.vr < `SDI_VAR_5W1 && !r.rd) `CHK(cap & m, ex[63:0])
        if (r.vr >= `SDI_VAR_5W1) `CHK(rs_cap, r.sel)
        if (r.rd) `CHK(rd_seen, expect_read(r))
    endtask
    initial begin
        #5_000_000;
        num_errors++;
        close_out();
    end
    initial begin
        sdi_row_t rows[7];
        int n;
        rows = '{'{1'b0, `SDI_VAR_4W, 5'h00, 16'h0, 1'b1, 1'b0, 5'h08, 16'ha500, 1'b1, 1'b0},
            '{1'b1, `SDI_VAR_3W, 5'h10, 16'hc3a5, 1'b0, 1'b0, 5'h10, 16'h1234, 1'b0, 1'b0},
            '{1'b0, `SDI_VAR_4W, 5'h03, 16'hffff, 1'b1, 1'b1, 5'h01, 16'h8000, 1'b0, 1'b0},
            '{1'b1, `SDI_VAR_5W1, 5'h00, 16'h0, 1'b1, 1'b0, 5'h08, 16'h5a00, 1'b1, 1'b0},
            '{1'b0, `SDI_VAR_5W2, 5'h02, 16'hffff, 1'b1, 1'b1, 5'h08, 16'h3c00, 1'b0, 1'b0},
            '{1'b1, `SDI_VAR_3W, 5'h00, 16'h0, 1'b1, 1'b0, 5'h10, 16'h0, 1'b0, 1'b1},
            '{1'b0, `SDI_VAR_4W, 5'h00, 16'h0, 1'b1, 1'b1, 5'h10, 16'h0, 1'b1, 1'b1}};
        repeat (2) @(posedge clk_sys);
        #1 reset = 1'b0;
        for (int k = 0; k < 7; k++)
            run_row(rows[k]);
        // Slow burst of one-bit words fills the queue
        setcfg(rows[2]);
        cfg_clk_div = 8'hff;
        n = 0;
        word_last = 1'b0;
        word_valid = 1'b1;
        repeat (40) begin
            if (word_ready === 1'b1) begin
                word_data = {n[0], 15'h0};
                n++;
            end
            @(posedge clk_sys);
            #1;
        end
        `CHK(word_ready, 1'b0)
        `CHK(n inside {[16:18]}, 1'b1)
        push(16'h8000, 1'b0, 1'b1);
        drain();
        `CHK(cnt, 8'(n + 6))
        `CHK(cap[1:0], {~n[0], 1'b1})
        // Reset in mid-frame, then recover
        cfg_clk_div = 8'h07;
        setcfg(rows[1]);
        push(rows[1].dat, 1'b0, 1'b1);
        repeat (50) @(posedge clk_sys);
        #1 reset = 1'b1;
        @(posedge clk_sys);
        #1 reset = 1'b0;
        `CHK(display_chip_select_n_ff, 2'h3)
        `CHK(serial_display_clock_ff, 1'b0)
        run_row(rows[0]);
        close_out();
    end
endmodule
